// ===== common/alarm_status_regs.vh
// register map, field positions and reset values of the alarm status bank
`ifndef ALARM_STATUS_REGS_VH
`define ALARM_STATUS_REGS_VH

// register addresses on the serial control port (16-bit register index)
`define ADDR_IRQ_ENABLE      16'h0079
`define ADDR_FACTORY_LOW     16'h007a
`define ADDR_FACTORY_HIGH    16'h007b
`define ADDR_STICKY_FLAGS    16'h0200
`define ADDR_STICKY_RSVD     16'h0201
`define ADDR_PIN_LEVELS      16'h020c
`define ADDR_GLOBAL_IRQ      16'h020d

// bit positions inside the sticky flag and enable bytes
`define BIT_LOCK_LOSS        6
`define BIT_HOLDOVER         4
`define BIT_SIGNAL_LOSS_IN1  1
`define BIT_SIGNAL_LOSS_IN0  0

// bit position of the summary bit in the global interrupt byte
`define BIT_GLOBAL_IRQ       0

// implemented bits of the sticky flag and enable bytes
`define STICKY_MASK          8'h53

// implemented bits of the pin level byte
`define PIN_LEVEL_MASK       8'h0f

// reset values
`define RST_FACTORY_LOW      8'h27
`define RST_FACTORY_HIGH     8'h14
`define RST_IRQ_ENABLE       8'h00
`define RST_STICKY_FLAGS     8'h00
`define RST_BYTE_ZERO        8'h00

`endif

// ===== rtl/alarm_sticky_status_bank.v
// sticky alarm status bank with interrupt summary and pin level byte
`timescale 1ns/1ps
`default_nettype none
`include "alarm_status_regs.vh"

module alarm_sticky_status_bank (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rstn,
   // register access from the serial control port engine
   input  wire [15:0] reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   output reg         reg_rvalid,
   // alarm levels from the monitor logic, other clock domains
   input  wire        lock_loss_alarm,
   input  wire        holdover_alarm,
   input  wire [1:0]  signal_loss_alarm,
   // general purpose pins and their direction setting
   input  wire [3:0]  gpio_pin_in,
   input  wire [3:0]  gpio_is_input,
   // open-drain interrupt pin, enable low while driving
   output reg         irq_out_n,
   output reg         irq_oe_n
);

   // address compare, used by the write decode; the read mux decodes with a case
   function addr_is;
      input [15:0] addr;
      input [15:0] target;
      begin
         addr_is = (addr == target);
      end
   endfunction

   // next value of one sticky flag: a new event beats the clear
   function sticky_next;
      input flag;
      input event_seen;
      input clear_req;
      begin
         sticky_next = event_seen | (flag & ~clear_req);
      end
   endfunction

   // settled copies of the alarm and pin inputs
   wire [7:0]  settled;
   wire        lock_loss_lvl;
   wire        holdover_lvl;
   wire [1:0]  signal_loss_lvl;
   wire [3:0]  pin_lvl;

   // previous alarm levels for rising-edge detection
   reg         lock_loss_prev;
   reg         holdover_prev;
   reg  [1:0]  signal_loss_prev;

   // storage
   reg  [7:0]  factory_setting_low;
   reg  [7:0]  factory_setting_high;
   reg  [7:0]  irq_enable;
   reg         lock_loss_flag;
   reg         holdover_flag;
   reg         signal_loss_flag_in0;
   reg         signal_loss_flag_in1;

   // decoded events and clear requests
   wire        lock_loss_event;
   wire        holdover_event;
   wire [1:0]  signal_loss_event;
   wire        wr_flags;
   wire [7:0]  clear_bits;

   // combinational views
   wire [7:0]  sticky_byte;
   wire [7:0]  pin_byte;
   wire        global_irq;
   reg  [7:0]  next_rdata;

   // alarms and pins cross into the register clock here
   sync_triple #(
      .W (8)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .async_in ({gpio_pin_in, signal_loss_alarm,
                  holdover_alarm, lock_loss_alarm}),
      .settled  (settled)
   );

   assign lock_loss_lvl   = settled[0];
   assign holdover_lvl    = settled[1];
   assign signal_loss_lvl = settled[3:2];
   assign pin_lvl         = settled[7:4];

   // remember last settled alarm levels
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lock_loss_prev   <= 1'b0;
         holdover_prev    <= 1'b0;
         signal_loss_prev <= 2'b00;
      end else begin
         lock_loss_prev   <= lock_loss_lvl;
         holdover_prev    <= holdover_lvl;
         signal_loss_prev <= signal_loss_lvl;
      end
   end

   // an alarm occurrence is the rising edge of its settled level
   assign lock_loss_event   = lock_loss_lvl & ~lock_loss_prev;
   assign holdover_event    = holdover_lvl & ~holdover_prev;
   assign signal_loss_event = signal_loss_lvl & ~signal_loss_prev;

   // write-one clear decode; reserved positions are ignored
   assign wr_flags   = reg_wr & addr_is(reg_addr, `ADDR_STICKY_FLAGS);
   assign clear_bits = wr_flags ? (reg_wdata & `STICKY_MASK)
                                : `RST_BYTE_ZERO;

   // sticky flags: set on event, held, cleared by written one
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lock_loss_flag       <= 1'b0;
         holdover_flag        <= 1'b0;
         signal_loss_flag_in0 <= 1'b0;
         signal_loss_flag_in1 <= 1'b0;
      end else begin
         lock_loss_flag <= sticky_next(lock_loss_flag,
                                       lock_loss_event,
                                       clear_bits[`BIT_LOCK_LOSS]);
         holdover_flag <= sticky_next(holdover_flag,
                                      holdover_event,
                                      clear_bits[`BIT_HOLDOVER]);
         signal_loss_flag_in0 <= sticky_next(signal_loss_flag_in0,
                                   signal_loss_event[0],
                                   clear_bits[`BIT_SIGNAL_LOSS_IN0]);
         signal_loss_flag_in1 <= sticky_next(signal_loss_flag_in1,
                                   signal_loss_event[1],
                                   clear_bits[`BIT_SIGNAL_LOSS_IN1]);
      end
   end

   // software-writable bytes: factory settings and interrupt enables
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         factory_setting_low  <= `RST_FACTORY_LOW;
         factory_setting_high <= `RST_FACTORY_HIGH;
         irq_enable           <= `RST_IRQ_ENABLE;
      end else if (reg_wr) begin
         if (addr_is(reg_addr, `ADDR_FACTORY_LOW)) begin
            factory_setting_low <= reg_wdata;
         end
         if (addr_is(reg_addr, `ADDR_FACTORY_HIGH)) begin
            factory_setting_high <= reg_wdata;
         end
         if (addr_is(reg_addr, `ADDR_IRQ_ENABLE)) begin
            irq_enable <= reg_wdata & `STICKY_MASK;
         end
      end
   end

   // sticky flags placed at their byte positions
   assign sticky_byte = {1'b0, lock_loss_flag, 1'b0, holdover_flag,
                         2'b00, signal_loss_flag_in1,
                         signal_loss_flag_in0};

   // only pins set as inputs show a level; others read zero
   assign pin_byte = {4'h0, pin_lvl & gpio_is_input};

   // any enabled flag raises the summary
   assign global_irq = |(sticky_byte & irq_enable);

   // read data mux; reserved and unmapped bytes read zero
   always @* begin
      next_rdata = `RST_BYTE_ZERO;
      case (reg_addr)
         `ADDR_IRQ_ENABLE: begin
            next_rdata = irq_enable;
         end
         `ADDR_FACTORY_LOW: begin
            next_rdata = factory_setting_low;
         end
         `ADDR_FACTORY_HIGH: begin
            next_rdata = factory_setting_high;
         end
         `ADDR_STICKY_FLAGS: begin
            next_rdata = sticky_byte;
         end
         `ADDR_PIN_LEVELS: begin
            next_rdata = pin_byte;
         end
         `ADDR_GLOBAL_IRQ: begin
            next_rdata = {7'h00, global_irq};
         end
         default: begin
            next_rdata = `RST_BYTE_ZERO;
         end
      endcase
   end

   // read answer one cycle after the read strobe
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata  <= `RST_BYTE_ZERO;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // interrupt pin pulled low while the summary is set
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_out_n <= 1'b1;
         irq_oe_n  <= 1'b1;
      end else begin
         irq_out_n <= ~global_irq;
         irq_oe_n  <= ~global_irq;
      end
   end

endmodule

`default_nettype wire

// ===== rtl/sync_triple.v
// three-stage input synchroniser with agreement filter on rising changes
`timescale 1ns/1ps
`default_nettype none

module sync_triple #(
   parameter W = 8
) (
   // clock and reset
   input  wire         clk_sys,
   input  wire         rstn,
   // asynchronous input and its settled copy
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] settled
);

   reg [W-1:0] stage_a;
   reg [W-1:0] stage_b;
   reg [W-1:0] stage_c;

   // stage_a feeds only stage_b; a rise counts once b and c agree, a fall as soon as they differ
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stage_a <= {W{1'b0}};
         stage_b <= {W{1'b0}};
         stage_c <= {W{1'b0}};
         settled <= {W{1'b0}};
      end else begin
         stage_a <= async_in;
         stage_b <= stage_a;
         stage_c <= stage_b;
         settled <= (settled & ~(stage_b ^ stage_c)) |
                    (stage_b & ~(stage_b ^ stage_c));
      end
   end

endmodule

`default_nettype wire

// ===== sim/alarm_bank_props.sv
// port assertions for the alarm status bank
`timescale 1ns/1ps
`default_nettype none
module alarm_bank_props (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rstn,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   // pins
   input wire logic [3:0]  gpio_is_input,
   input wire logic        irq_out_n,
   input wire logic        irq_oe_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // register port answers
   chk_read_answer: assert property (
      1 |=> reg_rvalid == $past(reg_rd))
      else $error("read answer timing wrong");
   chk_rdata_holds: assert property (
      !reg_rvalid |-> $stable(reg_rdata))
      else $error("read data moved without answer");
   chk_rsvd_byte: assert property (reg_rd && reg_addr == 16'h0201
      |=> reg_rdata == 8'h00) else $error("reserved byte not zero");
   chk_rsvd_bits: assert property (reg_rd && reg_addr == 16'h0200
      |=> (reg_rdata & 8'hac) == 8'h00) else $error("flag byte spare bits");
   chk_pin_byte: assert property (reg_rd && reg_addr == 16'h020c
      |=> (reg_rdata & {4'hf, ~$past(gpio_is_input)}) == 8'h00)
      else $error("pin byte shows non-input pin");
   // interrupt pin
   chk_pin_enable: assert property (irq_oe_n == irq_out_n)
      else $error("pin enable differs from pin value");
   chk_global_mirror: assert property (
      reg_rd && reg_addr == 16'h020d |=> reg_rdata == {7'h00, !irq_out_n})
      else $error("global bit off");
   chk_mask_quiet: assert property (reg_wr && reg_addr == 16'h0079
      && reg_wdata == 8'h00 |-> ##2 irq_out_n) else $error("pin low unmasked");
   cover property (reg_rvalid && reg_rdata != 8'h00);
   cover property ($fell(irq_out_n));
   cover property (reg_wr && reg_addr == 16'h0200);
endmodule
bind alarm_sticky_status_bank alarm_bank_props alarm_bank_props_i (
   .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .gpio_is_input(gpio_is_input), .irq_out_n(irq_out_n),
   .irq_oe_n(irq_oe_n));
`default_nettype wire

// ===== sim/alarm_sticky_status_bank_bench.sv
// testbench of the alarm status bank
`timescale 1ns/1ps
`default_nettype none
module alarm_sticky_status_bank_bench;
   logic        clk_sys = 1'b0;
   logic        rstn;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, q;
   logic        reg_wr, reg_rd, reg_rvalid, irq_out_n, irq_oe_n;
   logic [3:0]  alarm, gpio_pin_in, gpio_is_input; // alarm: lock,hold,in1,in0
   bit          ok;
   int          fails, n_compared, i;
   logic [7:0]  bits [4] = '{8'h40, 8'h10, 8'h02, 8'h01};
   always #4 clk_sys = ~clk_sys;
   alarm_sticky_status_bank alarm_sticky_status_bank_i (
      .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .lock_loss_alarm(alarm[3]), .holdover_alarm(alarm[2]),
      .signal_loss_alarm(alarm[1:0]), .gpio_pin_in(gpio_pin_in),
      .gpio_is_input(gpio_is_input), .irq_out_n(irq_out_n),
      .irq_oe_n(irq_oe_n));
   host_port_model host_port_model_i (
      .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input string s, input logic [7:0] e,
                      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rd_cmp(input logic [15:0] a, input logic [7:0] e);
      host_port_model_i.rd(a, q, ok);
      cmp("answer", 8'h01, {7'h00, ok});
      if (!ok)
         give_verdict;
      else
         cmp($sformatf("byte %h", a), e, q);
   endtask
   task automatic pin_cmp(input logic e);
      repeat (3) @(negedge clk_sys);
      cmp("irq_out_n", {7'h00, e}, {7'h00, irq_out_n});
      cmp("irq_oe_n", {7'h00, e}, {7'h00, irq_oe_n});
   endtask
   initial begin
      rstn = 1'b0;
      alarm = 4'h0;
      gpio_pin_in = 4'h0;
      gpio_is_input = 4'h0;
      repeat (6) @(negedge clk_sys);
      rstn = 1'b1;
      rd_cmp(16'h007a, 8'h27);
      rd_cmp(16'h007b, 8'h14);
      rd_cmp(16'h0200, 8'h00);
      rd_cmp(16'h0201, 8'h00);
      host_port_model_i.wr(16'h007a, 8'h5a);
      rd_cmp(16'h007a, 8'h5a);
      host_port_model_i.wr(16'h007b, 8'hc3);
      rd_cmp(16'h007b, 8'hc3);
      // every alarm: set, stays after removal, zero keeps, one clears
      for (i = 0; i < 4; i++) begin
         @(negedge clk_sys);
         alarm[3-i] = 1'b1;
         repeat (8) @(negedge clk_sys);
         rd_cmp(16'h0200, bits[i]);
         alarm[3-i] = 1'b0;
         repeat (8) @(negedge clk_sys);
         host_port_model_i.wr(16'h0200, ~bits[i]);
         rd_cmp(16'h0200, bits[i]);
         host_port_model_i.wr(16'h0200, bits[i]);
         rd_cmp(16'h0200, 8'h00);
      end
      // clear lands on the very edge at which the in1 event sets its flag
      @(negedge clk_sys);
      alarm[1] = 1'b1;
      repeat (3) @(negedge clk_sys);
      host_port_model_i.wr(16'h0200, 8'h02);
      alarm[1] = 1'b0;
      rd_cmp(16'h0200, 8'h02);
      // level already settled low at this clear: no new edge, no re-set
      host_port_model_i.wr(16'h0200, 8'h02);
      rd_cmp(16'h0200, 8'h00);
      // interrupt pin follows only enabled flags
      @(negedge clk_sys);
      alarm[3] = 1'b1;
      repeat (8) @(negedge clk_sys);
      alarm[3] = 1'b0;
      pin_cmp(1'b1);
      host_port_model_i.wr(16'h0079, 8'h10);
      pin_cmp(1'b1);
      host_port_model_i.wr(16'h0079, 8'h40);
      pin_cmp(1'b0);
      rd_cmp(16'h020d, 8'h01);
      rd_cmp(16'h0079, 8'h40);
      host_port_model_i.wr(16'h0079, 8'h00);
      pin_cmp(1'b1);
      rd_cmp(16'h020d, 8'h00);
      host_port_model_i.wr(16'h0079, 8'h40);
      pin_cmp(1'b0);
      host_port_model_i.wr(16'h0200, 8'h40);
      pin_cmp(1'b1);
      rd_cmp(16'h020d, 8'h00);
      // pin levels masked by direction
      gpio_pin_in = 4'ha;
      gpio_is_input = 4'h6;
      repeat (8) @(negedge clk_sys);
      rd_cmp(16'h020c, 8'h02);
      gpio_pin_in = 4'h5;
      gpio_is_input = 4'hf;
      repeat (8) @(negedge clk_sys);
      rd_cmp(16'h020c, 8'h05);
      // reset in mid-run brings back the factory and enable reset values
      @(negedge clk_sys);
      rstn = 1'b0;
      repeat (2) @(negedge clk_sys);
      rstn = 1'b1;
      rd_cmp(16'h007a, 8'h27);
      rd_cmp(16'h007b, 8'h14);
      rd_cmp(16'h0079, 8'h00);
      give_verdict;
   end
endmodule
`default_nettype wire

// ===== sim/host_port_model.sv
// host side of the register port: byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
   // clock
   input wire logic        clk_sys,
   // register port
   output logic [15:0]     reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid
);
   initial begin
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // write one byte; spare bits of flag and enable bytes go out zero
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = (a == 16'h0200 || a == 16'h0079) ?
                  d & 8'h53 : d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_addr = ~a; // idle bus never shows a stale value
      reg_wdata = ~reg_wdata;
   endtask
   // read one byte; ok stays low if no answer within four cycles
   task automatic rd(input logic [15:0] a, output logic [7:0] q,
                     output bit ok);
      int n;
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      ok = 1'b0;
      q = 8'h00;
      for (n = 0; n < 4 && !ok; n++) begin
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            q = reg_rdata;
         end else
            @(negedge clk_sys);
      end
   endtask
endmodule
`default_nettype wire
